// ---- fsw_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsw_dev
  import fsw_pkg::*;
#(
  parameter int unsigned MAX_CYC   = FLASH_MAX_CYC,
  parameter int unsigned STEP_CYC  = FLASH_STEP_CYC,
  parameter int unsigned SHORT_CYC = SHORT_WAIT_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Link to host
  fsw_if.dev              bus,
  // Analog sense
  input  wire logic       overvoltage_in,
  input  wire logic       overtemp_in,
  input  wire logic       cathode_grounded_in,
  // LED driver controls and fault flags
  output logic            flash_on_out,
  output logic            torch_on_out,
  output logic [4:0]      led_level_out,
  output logic [3:0]      fault_out
);
  fsw_state_e  st_q;
  logic [7:0]  out_sel_q;
  logic [7:0]  config_q;
  logic [3:0]  fault_q;
  logic        trig_q;
  logic        sw_pulse_q;
  logic        sw_hold_q;
  logic        pin_mode;
  logic        both_high;
  logic        both_low;
  logic        bus_wr;
  logic        armed;
  logic        torch;
  logic        timed;
  logic        start;
  logic        strobe_lvl;
  logic        expire;
  logic        wdt_run;
  logic [3:0]  code;
  logic [31:0] sc_cnt_q;
  logic        clear;

  assign pin_mode  = bus.interface_select_pin;
  assign both_high = bus.mode_select_pin_high && bus.mode_select_pin_low;
  assign both_low  = !bus.mode_select_pin_high && !bus.mode_select_pin_low;
  assign bus_wr    = bus.wr_valid && !pin_mode && (bus.wr_addr == DEV_ADDR_W);
  assign armed     = out_sel_q[4:0] >= FLASH_MIN_CODE;
  assign torch     = pin_mode ? (bus.mode_select_pin_high && !bus.mode_select_pin_low)
                              : (out_sel_q[4:0] != 5'h00 && out_sel_q[4:0] <= TORCH_MAX_CODE);
  assign timed     = config_q[TIMED_BIT] && !pin_mode;
  assign code      = pin_mode ? 4'h0 : config_q[3:0];
  assign clear     = pin_mode ? both_low
                              : (bus_wr && bus.wr_sub == REG_OUT_SEL && bus.wr_data == 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // Registers; power-on reset gives defaults
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      out_sel_q <= OUT_SEL_RST;
      config_q  <= CONFIG_RST;
    end else if (bus_wr) begin
      if (bus.wr_sub == REG_OUT_SEL) out_sel_q <= bus.wr_data;
      if (bus.wr_sub == REG_CONFIG) config_q <= bus.wr_data;
    end
  end

  // Software trigger: pulse starts, level held for user mode until bit rewritten 0 or the flash ends
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sw_pulse_q <= 1'b0;
      sw_hold_q  <= 1'b0;
    end else begin
      sw_pulse_q <= bus_wr && bus.wr_sub == REG_SW_TRIG && bus.wr_data[0];
      if (bus_wr && bus.wr_sub == REG_SW_TRIG) sw_hold_q <= bus.wr_data[0];
      else if (st_q != FSW_FLASH && !sw_pulse_q) sw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) trig_q <= 1'b0;
    else        trig_q <= bus.flash_trigger_pin;
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash sequencing
  assign strobe_lvl = pin_mode ? both_high : (bus.flash_trigger_pin || sw_hold_q);
  assign start = (fault_q == 4'h0) && (st_q == FSW_IDLE) &&
                 (pin_mode ? both_high
                           : armed && ((bus.flash_trigger_pin && !trig_q) || sw_pulse_q));
  assign wdt_run = (st_q == FSW_FLASH);

  fsw_wdt #(.MAX_CYC(MAX_CYC), .STEP_CYC(STEP_CYC)) u_wdt (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .start_in   (start),
    .run_in     (wdt_run),
    .code_in    (code),
    .expire_out (expire)
  );

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= FSW_IDLE;
    end else begin
      case (st_q)
        FSW_IDLE:  if (start) st_q <= FSW_FLASH;
        FSW_FLASH: begin
          if (fault_q != 4'h0 || overvoltage_in || overtemp_in) st_q <= FSW_HALT;
          else if (expire) st_q <= timed ? FSW_IDLE : FSW_HALT;
          else if (!timed && !strobe_lvl) st_q <= FSW_IDLE;
          else if (!pin_mode && !armed) st_q <= FSW_IDLE;
        end
        // Leave once the fault word is empty; a one-cycle clear write has gone by then
        FSW_HALT:  if (fault_q == 4'h0) st_q <= FSW_IDLE;
        default:   st_q <= FSW_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Faults; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sc_cnt_q <= 32'h0;
    end else if (torch && cathode_grounded_in && fault_q == 4'h0) begin
      if (sc_cnt_q < SHORT_CYC) sc_cnt_q <= sc_cnt_q + 32'h1;
    end else begin
      sc_cnt_q <= 32'h0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fault_q <= 4'h0;
    end else begin
      fault_q[OV_BIT]  <= overvoltage_in || (fault_q[OV_BIT] && !clear);
      fault_q[OT_BIT]  <= overtemp_in || (fault_q[OT_BIT] && !clear);
      fault_q[TMO_BIT] <= (st_q == FSW_FLASH && expire && !timed)
                          || (fault_q[TMO_BIT] && !clear);
      fault_q[SC_BIT]  <= (sc_cnt_q + 32'h1 >= SHORT_CYC && torch && cathode_grounded_in)
                          || (fault_q[SC_BIT] && !clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flash_on_out  <= 1'b0;
      torch_on_out  <= 1'b0;
      led_level_out <= 5'h00;
      bus.rd_valid  <= 1'b0;
      bus.rd_data   <= 8'h00;
    end else begin
      flash_on_out  <= (st_q == FSW_FLASH) && (fault_q == 4'h0);
      torch_on_out  <= torch && (fault_q == 4'h0) && (st_q != FSW_HALT);
      led_level_out <= pin_mode ? 5'h00 : out_sel_q[4:0];
      bus.rd_valid  <= bus.wr_valid && !pin_mode && (bus.wr_addr == (DEV_ADDR_W | 8'h01));
      // Read data holds between requests
      if (bus.wr_valid && !pin_mode && (bus.wr_addr == (DEV_ADDR_W | 8'h01))) begin
        case (bus.wr_sub)
          REG_OUT_SEL: bus.rd_data <= out_sel_q;
          REG_CONFIG:  bus.rd_data <= config_q;
          REG_FAULT:   bus.rd_data <= {4'h0, fault_q};
          default:     bus.rd_data <= 8'h00;
        endcase
      end
    end
  end
  assign fault_out    = fault_q;
  assign bus.irq_o    = 1'b0;
  assign bus.irq_oe_n = (fault_q == 4'h0);
endmodule
`default_nettype wire

// ---- fsw_pkg.sv ----
`default_nettype none
package fsw_pkg;
  // Clock, watchdog and short-circuit timing
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned FLASH_MAX_MS    = 820;
  localparam int unsigned FLASH_STEP_US   = 54600;
  localparam int unsigned SHORT_WAIT_MS   = 820;
  localparam int unsigned FLASH_MAX_CYC   = FLASH_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_STEP_CYC  = FLASH_STEP_US * (CLK_HZ / 1000000);
  localparam int unsigned SHORT_WAIT_CYC  = SHORT_WAIT_MS * (CLK_HZ / 1000);
  // Bus address and register offsets
  localparam logic [7:0] DEV_ADDR_W       = 8'h60;
  localparam logic [1:0] REG_OUT_SEL      = 2'h0;
  localparam logic [1:0] REG_CONFIG       = 2'h1;
  localparam logic [1:0] REG_SW_TRIG      = 2'h2;
  localparam logic [1:0] REG_FAULT        = 2'h3;
  // Field positions
  localparam int unsigned OV_BIT          = 0;
  localparam int unsigned TMO_BIT         = 1;
  localparam int unsigned OT_BIT          = 2;
  localparam int unsigned SC_BIT          = 3;
  localparam int unsigned TIMED_BIT       = 4;
  localparam int unsigned CODE_LO         = 0;
  // Power LED code ranges
  localparam logic [4:0] TORCH_MAX_CODE   = 5'h0B;
  localparam logic [4:0] FLASH_MIN_CODE   = 5'h0C;
  // Reset values
  localparam logic [7:0] OUT_SEL_RST      = 8'h00;
  localparam logic [7:0] CONFIG_RST       = 8'h00;
  typedef enum logic [1:0] {FSW_IDLE, FSW_FLASH, FSW_HALT} fsw_state_e;
endpackage
`default_nettype wire

// ---- fsw_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface fsw_if;
  // Interface select: 1 pin control, 0 register bus
  logic       interface_select_pin;
  logic       mode_select_pin_high;
  logic       mode_select_pin_low;
  logic       flash_trigger_pin;
  // Register write/read port (byte-level bus transactions)
  logic       wr_valid;
  logic [7:0] wr_addr;
  logic [1:0] wr_sub;
  logic [7:0] wr_data;
  logic       rd_valid;
  logic [7:0] rd_data;
  // Open-drain interrupt, oe low means pulling low
  logic       irq_o;
  logic       irq_oe_n;
  modport dev  (input interface_select_pin, mode_select_pin_high, mode_select_pin_low,
                flash_trigger_pin, wr_valid, wr_addr, wr_sub, wr_data,
                output rd_valid, rd_data, irq_o, irq_oe_n);
  modport host (output interface_select_pin, mode_select_pin_high, mode_select_pin_low,
                flash_trigger_pin, wr_valid, wr_addr, wr_sub, wr_data,
                input rd_valid, rd_data, irq_o, irq_oe_n);
endinterface
`default_nettype wire

// ---- fsw_wdt.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsw_wdt
  import fsw_pkg::*;
#(
  parameter int unsigned MAX_CYC  = FLASH_MAX_CYC,
  parameter int unsigned STEP_CYC = FLASH_STEP_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       start_in,
  input  wire logic       run_in,
  input  wire logic [3:0] code_in,
  // Status
  output logic            expire_out
);
  logic [31:0] cnt_q;
  logic [31:0] limit;
  // Period shrinks by one step per code count
  assign limit = MAX_CYC - STEP_CYC * {28'h0, code_in};

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 32'h0;
    end else if (start_in || !run_in) begin
      cnt_q <= 32'h0;
    end else if (cnt_q < limit) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  assign expire_out = run_in && !start_in && (cnt_q + 32'h1 >= limit);
endmodule
`default_nettype wire

// ---- fsw_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsw_host
  import fsw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Link to device
  fsw_if.host             bus,
  // User side
  input  wire logic       pin_mode_in,
  input  wire logic [1:0] mode_pins_in,
  input  wire logic       strobe_in,
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_read_in,
  input  wire logic [1:0] cmd_sub_in,
  input  wire logic [7:0] cmd_data_in,
  output logic            rd_valid_out,
  output logic [7:0]      rd_data_out,
  output logic            irq_seen_out
);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus.interface_select_pin <= 1'b0;
      bus.mode_select_pin_high <= 1'b0;
      bus.mode_select_pin_low  <= 1'b0;
      bus.flash_trigger_pin    <= 1'b0;
      bus.wr_valid             <= 1'b0;
      bus.wr_addr              <= 8'h00;
      bus.wr_sub               <= 2'h0;
      bus.wr_data              <= 8'h00;
    end else begin
      bus.interface_select_pin <= pin_mode_in;
      bus.mode_select_pin_high <= mode_pins_in[1];
      bus.mode_select_pin_low  <= mode_pins_in[0];
      bus.flash_trigger_pin    <= strobe_in;
      bus.wr_valid             <= cmd_valid_in;
      bus.wr_addr              <= cmd_read_in ? (DEV_ADDR_W | 8'h01) : DEV_ADDR_W;
      bus.wr_sub               <= cmd_sub_in;
      bus.wr_data              <= cmd_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 8'h00;
      irq_seen_out <= 1'b0;
    end else begin
      rd_valid_out <= bus.rd_valid;
      if (bus.rd_valid) rd_data_out <= bus.rd_data;
      irq_seen_out <= !bus.irq_oe_n;
    end
  end
endmodule
`default_nettype wire

// ---- fsw_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsw_chk
  import fsw_pkg::*;
#(
  parameter int unsigned MAX_CYC = 200
) (
  // Clock, reset and link signals
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  input wire logic       interface_select_pin,
  input wire logic       mode_select_pin_high,
  input wire logic       mode_select_pin_low,
  input wire logic       flash_trigger_pin,
  input wire logic       wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [1:0] wr_sub,
  input wire logic [7:0] wr_data,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic       irq_o,
  input wire logic       irq_oe_n
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Recent clear requests; the device may take a few edges to act
  logic        clr_now;
  logic        isp_q;
  logic [3:0]  clr_q;
  int unsigned pin_cnt_q;
  assign clr_now = (wr_valid && wr_addr == DEV_ADDR_W && wr_sub == REG_OUT_SEL
                    && wr_data == 8'h00 && !interface_select_pin)
                   || (interface_select_pin && !mode_select_pin_high && !mode_select_pin_low)
                   || (interface_select_pin != isp_q);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      clr_q     <= 4'h0;
      isp_q     <= 1'h0;
      pin_cnt_q <= 32'h0;
    end else begin
      clr_q     <= {clr_q[2:0], clr_now};
      isp_q     <= interface_select_pin;
      pin_cnt_q <= (interface_select_pin && mode_select_pin_high && mode_select_pin_low)
                   ? pin_cnt_q + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd_req;
    wr_valid && wr_addr == (DEV_ADDR_W | 8'h01) && !interface_select_pin;
  endsequence
  sequence s_quiet;
    !clr_now && clr_q == 4'h0;
  endsequence
  chk_irq_drive_low: assert property (irq_o == 1'h0)
    else $error("interrupt drive level not low");
  chk_host_addr_legal: assert property (wr_valid |-> wr_addr == DEV_ADDR_W || wr_addr == (DEV_ADDR_W | 8'h01))
    else $error("host used a foreign address");
  chk_read_answer: assert property (s_rd_req |=> rd_valid)
    else $error("read not answered");
  chk_read_cause: assert property (rd_valid |-> $past(wr_valid && wr_addr == (DEV_ADDR_W | 8'h01) && !interface_select_pin))
    else $error("read answer without request");
  chk_read_hold: assert property (!$past(wr_valid) |-> $stable(rd_data))
    else $error("read data moved without request");
  chk_fault_upper: assert property (rd_valid && $past(wr_sub) == REG_FAULT |-> rd_data[7:4] == 4'h0)
    else $error("fault readback upper bits set");
  // Slack covers pin sampling and start latency
  chk_pin_timeout: assert property (pin_cnt_q >= MAX_CYC + 8 |-> !irq_oe_n)
    else $error("pin flash overran without interrupt");
  chk_fault_hold: assert property (!irq_oe_n ##0 s_quiet |=> !irq_oe_n)
    else $error("interrupt released without clear");
  chk_release_cause: assert property ($rose(irq_oe_n) |-> clr_q != 4'h0)
    else $error("interrupt rose with no clear request");
endmodule
`default_nettype wire

// ---- tb_flash_strobe_watchdog_fault.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_flash_strobe_watchdog_fault;
  import fsw_pkg::*;
  localparam int MAXC = 200;
  localparam int STEPC = 10;
  localparam int SHORTC = 50;
  logic clk_sys_in = 1'h0, rst_in = 1'h1, ov = 1'h0, ot = 1'h0, cg = 1'h0;
  logic pin_mode = 1'h0, strobe = 1'h0, cmd_valid = 1'h0, cmd_read = 1'h0;
  logic [1:0] mode_pins = 2'h0, cmd_sub = 2'h0;
  logic [7:0] cmd_data = 8'h00, rd_data;
  logic flash_on, torch_on, rd_valid;
  logic [4:0] led_level;
  logic [3:0] fault;
  int miscompares = 0, total_checks = 0, n, code, dcode, elen;
  fsw_if bus_if();
  fsw_dev #(.MAX_CYC(MAXC), .STEP_CYC(STEPC), .SHORT_CYC(SHORTC)) fsw_dev_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(bus_if), .overvoltage_in(ov),
    .overtemp_in(ot), .cathode_grounded_in(cg), .flash_on_out(flash_on),
    .torch_on_out(torch_on), .led_level_out(led_level), .fault_out(fault));
  fsw_host fsw_host_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(bus_if), .pin_mode_in(pin_mode),
    .mode_pins_in(mode_pins), .strobe_in(strobe), .cmd_valid_in(cmd_valid),
    .cmd_read_in(cmd_read), .cmd_sub_in(cmd_sub), .cmd_data_in(cmd_data),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .irq_seen_out());
  fsw_chk #(.MAX_CYC(MAXC)) fsw_chk_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .interface_select_pin(bus_if.interface_select_pin),
    .mode_select_pin_high(bus_if.mode_select_pin_high),
    .mode_select_pin_low(bus_if.mode_select_pin_low),
    .flash_trigger_pin(bus_if.flash_trigger_pin), .wr_valid(bus_if.wr_valid),
    .wr_addr(bus_if.wr_addr), .wr_sub(bus_if.wr_sub), .wr_data(bus_if.wr_data),
    .rd_valid(bus_if.rd_valid), .rd_data(bus_if.rd_data), .irq_o(bus_if.irq_o),
    .irq_oe_n(bus_if.irq_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask
  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmd(input logic rd, input logic [1:0] sub, input logic [7:0] d);
    cmd_valid <= 1'h1;
    cmd_read <= rd;
    cmd_sub <= sub;
    cmd_data <= d;
    tick(1);
    cmd_valid <= 1'h0;
    tick(4);
  endtask
  // Waits out flash latency, then counts lit cycles
  task automatic measure(output int len);
    len = 0;
    for (int i = 0; i < 40 && flash_on !== 1'h1; i++) tick(1);
    while (flash_on === 1'h1 && len < 400) begin
      tick(1);
      len++;
    end
  endtask
  // Readback only in bus mode; pin mode ignores requests
  task automatic fchk(input logic [3:0] e, input logic bus);
    tick(6);
    `CHK(fault, e)
    `CHK(bus_if.irq_oe_n, e == 4'h0)
    if (bus) begin
      cmd_valid <= 1'h1;
      cmd_read <= 1'h1;
      cmd_sub <= REG_FAULT;
      tick(1);
      cmd_valid <= 1'h0;
      for (int i = 0; i < 20 && rd_valid !== 1'h1; i++) tick(1);
      `CHK(rd_data, {4'h0, e})
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(30000);
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(64));
    tick(6);
    rst_in <= 1'h0;
    tick(2);
    // User software, timed software, user pin, timed pin strobes
    for (int m = 0; m < 4; m++) begin
      code = 12 + $urandom % 20;
      dcode = $urandom % 16;
      cmd(1'h0, REG_CONFIG, {3'h0, m[0], dcode[3:0]});
      cmd(1'h0, REG_OUT_SEL, {3'h0, code[4:0]});
      `CHK(led_level, code[4:0])
      `CHK(flash_on, 1'h0)
      if (m < 2) cmd(1'h0, REG_SW_TRIG, 8'h01);
      else strobe <= 1'h1;
      if (m < 2) measure(n);
      else fork
        measure(n);
        begin
          tick(m == 2 ? 20 : 5);
          strobe <= 1'h0;
        end
      join
      elen = (m == 2) ? 20 : MAXC - STEPC * dcode;
      `CHK(n >= elen - 4 && n <= elen + 4, 1'h1)
      cmd(1'h0, REG_SW_TRIG, 8'h00);
      fchk(m == 0 ? 4'h2 : 4'h0, 1'h1);
      cmd(1'h0, REG_OUT_SEL, 8'h00);
      fchk(4'h0, 1'h1);
    end
    // Torch short, overvoltage, overtemperature
    for (int k = 0; k < 3; k++) begin
      cmd(1'h0, REG_OUT_SEL, 8'h05);
      `CHK(torch_on, 1'h1)
      if (k == 0) cg <= 1'h1;
      else if (k == 1) ov <= 1'h1;
      else ot <= 1'h1;
      tick(k == 0 ? SHORTC + 4 : 2);
      cg <= 1'h0;
      ov <= 1'h0;
      ot <= 1'h0;
      fchk(k == 0 ? 4'h8 : k == 1 ? 4'h1 : 4'h4, 1'h1);
      `CHK(torch_on, 1'h0)
      if (k == 2) begin
        rst_in <= 1'h1;
        tick(2);
        rst_in <= 1'h0;
        fchk(4'h0, 1'h1);
        `CHK(led_level, 5'h00)
      end
      cmd(1'h0, REG_OUT_SEL, 8'h00);
      fchk(4'h0, 1'h1);
    end
    // Pin mode: early end, then watchdog restart and overrun
    pin_mode <= 1'h1;
    tick(3);
    mode_pins <= 2'h3;
    fork
      measure(n);
      begin
        tick(30);
        mode_pins <= 2'h2;
      end
    join
    `CHK(n >= 24 && n <= 34, 1'h1)
    mode_pins <= 2'h0;
    tick(3);
    mode_pins <= 2'h3;
    measure(n);
    `CHK(n >= MAXC - 4 && n <= MAXC + 4, 1'h1)
    fchk(4'h2, 1'h0);
    mode_pins <= 2'h0;
    fchk(4'h0, 1'h0);
    stop_test();
  end
endmodule
`default_nettype wire
